// ===== hdl/bfo_defines.svh
// Purpose: constants of the bit and flag operations unit
// Assumes: 8-bit data, 32 working registers, 50 MHz core clock
// Notes: status flag bit positions follow the usual I T H S V N Z C order
//
// Functional notes
// RULE_01: left shift, bit 0 gets zero
// RULE_02: logical right shift, bit 7 gets zero
// RULE_03: rotate left, carry in, bit 7 out
// RULE_04: rotate right, carry in, bit 0 out
// RULE_05: arithmetic right shift keeps sign bit
// RULE_06: shifts update zero, carry, negative, overflow
// RULE_07: swap exchanges nibbles, flags untouched
// RULE_08: generic flag set/clear touches one bit
// RULE_09: store bit copies register bit to T
// RULE_10: load bit writes T into register bit
// RULE_11: carry raise and drop, carry only
// RULE_12: negative raise and drop, negative only
// RULE_13: zero raise and drop, zero only
// RULE_14: global interrupt enable on and off
// RULE_15: signed flag raise and drop only
// RULE_16: overflow flag raise and drop only
// RULE_17: transfer flag raise and drop only
// RULE_18: every operation finishes in one cycle
// RULE_19: results return to the operand register
`ifndef BFO_DEFINES_SVH
`define BFO_DEFINES_SVH

`define BFO_DW 8
`define BFO_NREGS 32
`define BFO_RAW 5
`define BFO_BUS_AW 6
`define BFO_ADDR_STATUS_FLAGS_REGISTER 6'h20
`define BFO_STATUS_FLAGS_REGISTER_RST 8'h00
`define BFO_REG_RST 8'h00
`define BFO_EXEC_CYCLES 1

`define BFO_FLAG_C 3'h0
`define BFO_FLAG_Z 3'h1
`define BFO_FLAG_N 3'h2
`define BFO_FLAG_V 3'h3
`define BFO_FLAG_S 3'h4
`define BFO_FLAG_H 3'h5
`define BFO_FLAG_T 3'h6
`define BFO_FLAG_I 3'h7

`endif

// ===== hdl/bfo_pkg.sv
// Purpose: types of the bit and flag operations unit
// Assumes: constants come from the defines header
// Notes: operation codes are decoded upstream
`include "bfo_defines.svh"
package bfo_pkg;
  typedef enum logic [4:0] {
    op_nop,
    op_shift_left_logical,
    op_shift_right_logical,
    op_rotate_left_carry,
    op_rotate_right_carry,
    op_arith_shift_right,
    op_swap_nibbles,
    op_status_bit_raise,
    op_status_bit_drop,
    op_store_bit_to_flag,
    op_load_bit_from_flag,
    op_carry_raise,
    op_carry_drop,
    op_negative_raise,
    op_negative_drop,
    op_zero_raise,
    op_zero_drop,
    op_irq_global_on,
    op_irq_global_off,
    op_sign_raise,
    op_sign_drop,
    op_overflow_raise,
    op_overflow_drop,
    op_transfer_flag_raise,
    op_transfer_flag_drop
  } bfo_op_t;

  typedef struct packed {
    logic [`BFO_DW-1:0] flags;
    logic [`BFO_DW-1:0] rdata;
  } bfo_state_t;
endpackage

// ===== hdl/bfo_rf_if.sv
// Purpose: link between the unit and its working registers
// Assumes: three combinational read ports, one write port
// Notes: reads see the value before this cycle's write
`include "bfo_defines.svh"
interface bfo_rf_if;
  logic wr_en;
  logic [`BFO_RAW-1:0] wr_addr;
  logic [`BFO_DW-1:0] wr_data;
  logic [`BFO_RAW-1:0] ra_addr;
  logic [`BFO_DW-1:0] ra_data;
  logic [`BFO_RAW-1:0] rb_addr;
  logic [`BFO_DW-1:0] rb_data;
  logic [`BFO_RAW-1:0] rc_addr;
  logic [`BFO_DW-1:0] rc_data;
  modport core (output wr_en, output wr_addr, output wr_data,
    output ra_addr, input ra_data, output rb_addr, input rb_data,
    output rc_addr, input rc_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
    input ra_addr, output ra_data, input rb_addr, output rb_data,
    input rc_addr, output rc_data);
endinterface

// ===== hdl/bfo_regs.sv
// Purpose: working register array
// Assumes: single write port, written at the clock edge
// Notes: reads are combinational so an operation fits one cycle
`include "bfo_defines.svh"
module bfo_regs
  import bfo_pkg::*;
#(
  parameter int NREGS = `BFO_NREGS
) (
  input wire logic clk,
  input wire logic sys_rst,
  bfo_rf_if.mem rf
);
  typedef struct packed {
    logic [NREGS-1:0][`BFO_DW-1:0] regs;
  } bfo_regs_state_t;

  bfo_regs_state_t st;
  bfo_regs_state_t next_st;

  always_comb begin
    next_st = st;
    if (rf.wr_en) begin
      next_st.regs[rf.wr_addr] = rf.wr_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rf.ra_data = st.regs[rf.ra_addr];
  assign rf.rb_data = st.regs[rf.rb_addr];
  assign rf.rc_data = st.regs[rf.rc_addr];
endmodule

// ===== hdl/bfo_unit.sv
// Purpose: shift, rotate, swap, bit transfer and flag operations
// Assumes: decoder gives one operation per cycle with op_valid
// Notes: registers and status flags also reachable on a plain port
`include "bfo_defines.svh"
module bfo_unit
  import bfo_pkg::*;
#(
  parameter int NREGS = `BFO_NREGS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire bfo_op_t op_code,
  input wire logic [`BFO_RAW-1:0] dst_sel,
  input wire logic [`BFO_RAW-1:0] src_sel,
  input wire logic [2:0] bit_sel,
  input wire logic [2:0] flag_sel,
  input wire logic [`BFO_BUS_AW-1:0] bus_addr,
  input wire logic [`BFO_DW-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [`BFO_DW-1:0] bus_rdata,
  output logic [`BFO_DW-1:0] status_flags,
  output logic irq_enable
);
  bfo_rf_if rf ();

  bfo_state_t st;
  bfo_state_t next_st;

  logic [`BFO_DW-1:0] opnd;
  logic [`BFO_DW-1:0] src;
  logic [`BFO_DW-1:0] res;
  logic cout;
  logic is_shift;
  logic is_flag;
  logic flag_val;
  logic [2:0] flag_idx;
  logic op_wr;
  logic bus_reg_hit;

  bfo_regs #(
    .NREGS(NREGS)
  ) u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .rf(rf.mem)
  );

  assign rf.ra_addr = dst_sel;
  assign rf.rb_addr = src_sel;
  assign rf.rc_addr = bus_addr[`BFO_RAW-1:0];
  assign opnd = rf.ra_data;
  assign src = rf.rb_data;
  assign bus_reg_hit = (bus_addr < `BFO_BUS_AW'(NREGS));

  always_comb begin
    next_st = st;
    res = opnd;
    cout = st.flags[`BFO_FLAG_C];
    is_shift = 1'b0;
    is_flag = 1'b0;
    flag_val = 1'b0;
    flag_idx = flag_sel;
    op_wr = 1'b0;
    if (op_valid) begin
      unique case (op_code)
        op_nop: begin
        end
        op_shift_left_logical: begin
          res = {opnd[6:0], 1'b0}; // RULE_01
          cout = opnd[7];
          is_shift = 1'b1;
          op_wr = 1'b1;
        end
        op_shift_right_logical: begin
          res = {1'b0, opnd[7:1]}; // RULE_02
          cout = opnd[0];
          is_shift = 1'b1;
          op_wr = 1'b1;
        end
        op_rotate_left_carry: begin
          res = {opnd[6:0], st.flags[`BFO_FLAG_C]}; // RULE_03
          cout = opnd[7]; // RULE_03
          is_shift = 1'b1;
          op_wr = 1'b1;
        end
        op_rotate_right_carry: begin
          res = {st.flags[`BFO_FLAG_C], opnd[7:1]}; // RULE_04
          cout = opnd[0]; // RULE_04
          is_shift = 1'b1;
          op_wr = 1'b1;
        end
        op_arith_shift_right: begin
          res = {opnd[7], opnd[7:1]}; // RULE_05
          cout = opnd[0];
          is_shift = 1'b1;
          op_wr = 1'b1;
        end
        op_swap_nibbles: begin
          res = {opnd[3:0], opnd[7:4]}; // RULE_07
          op_wr = 1'b1;
        end
        op_status_bit_raise: begin
          is_flag = 1'b1; // RULE_08
          flag_val = 1'b1;
        end
        op_status_bit_drop: begin
          is_flag = 1'b1; // RULE_08
        end
        op_store_bit_to_flag: begin
          is_flag = 1'b1;
          flag_idx = `BFO_FLAG_T;
          flag_val = src[bit_sel]; // RULE_09
        end
        op_load_bit_from_flag: begin
          res[bit_sel] = st.flags[`BFO_FLAG_T]; // RULE_10
          op_wr = 1'b1;
        end
        op_carry_raise, op_carry_drop: begin
          is_flag = 1'b1; // RULE_11
          flag_idx = `BFO_FLAG_C;
          flag_val = (op_code == op_carry_raise);
        end
        op_negative_raise, op_negative_drop: begin
          is_flag = 1'b1; // RULE_12
          flag_idx = `BFO_FLAG_N;
          flag_val = (op_code == op_negative_raise);
        end
        op_zero_raise, op_zero_drop: begin
          is_flag = 1'b1; // RULE_13
          flag_idx = `BFO_FLAG_Z;
          flag_val = (op_code == op_zero_raise);
        end
        op_irq_global_on, op_irq_global_off: begin
          is_flag = 1'b1; // RULE_14
          flag_idx = `BFO_FLAG_I;
          flag_val = (op_code == op_irq_global_on);
        end
        op_sign_raise, op_sign_drop: begin
          is_flag = 1'b1; // RULE_15
          flag_idx = `BFO_FLAG_S;
          flag_val = (op_code == op_sign_raise);
        end
        op_overflow_raise, op_overflow_drop: begin
          is_flag = 1'b1; // RULE_16
          flag_idx = `BFO_FLAG_V;
          flag_val = (op_code == op_overflow_raise);
        end
        op_transfer_flag_raise, op_transfer_flag_drop: begin
          is_flag = 1'b1; // RULE_17
          flag_idx = `BFO_FLAG_T;
          flag_val = (op_code == op_transfer_flag_raise);
        end
        default: begin
        end
      endcase
    end
    // shift flags; signed flag left alone, only Z C N V listed
    if (is_shift) begin
      next_st.flags[`BFO_FLAG_C] = cout; // RULE_06
      next_st.flags[`BFO_FLAG_Z] = (res == `BFO_DW'h00); // RULE_06
      next_st.flags[`BFO_FLAG_N] = res[7]; // RULE_06
      next_st.flags[`BFO_FLAG_V] = res[7] ^ cout; // RULE_06
    end
    if (is_flag) begin
      next_st.flags[flag_idx] = flag_val; // RULE_08
    end
    // an operation owns the cycle; a bus write beside it is dropped
    if (!op_valid && bus_wr && bus_addr == `BFO_ADDR_STATUS_FLAGS_REGISTER) begin
      next_st.flags = bus_wdata;
    end
    next_st.rdata = `BFO_DW'h00;
    if (bus_rd) begin
      if (bus_reg_hit) begin
        next_st.rdata = rf.rc_data;
      end else if (bus_addr == `BFO_ADDR_STATUS_FLAGS_REGISTER) begin
        next_st.rdata = st.flags;
      end
    end
  end

  always_comb begin
    rf.wr_en = 1'b0;
    rf.wr_addr = dst_sel;
    rf.wr_data = res;
    if (op_wr) begin
      rf.wr_en = 1'b1; // RULE_18
      rf.wr_addr = dst_sel; // RULE_19
      rf.wr_data = res;
    end else if (!op_valid && bus_wr && bus_reg_hit) begin
      rf.wr_en = 1'b1;
      rf.wr_addr = bus_addr[`BFO_RAW-1:0];
      rf.wr_data = bus_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{flags: `BFO_STATUS_FLAGS_REGISTER_RST, rdata: `BFO_DW'h00};
    end else begin
      st <= next_st;
    end
  end

  assign bus_rdata = st.rdata;
  assign status_flags = st.flags;
  assign irq_enable = st.flags[`BFO_FLAG_I];

  function automatic logic is_op(bfo_op_t o);
    return op_valid && op_code == o;
  endfunction

  a_shl_data: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    is_op(op_shift_left_logical) |->
      rf.wr_data == {opnd[6:0], 1'b0}
      ##1 status_flags[`BFO_FLAG_C] == $past(opnd[7]))
    else $error("left shift result or carry wrong");

  a_shr_data: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    is_op(op_shift_right_logical) |->
      rf.wr_data[7] == 1'b0 && rf.wr_data[6:0] == opnd[7:1]
      ##1 !status_flags[`BFO_FLAG_N])
    else $error("logical right shift wrong");

  a_rol_carry: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    is_op(op_rotate_left_carry) |->
      rf.wr_data[0] == status_flags[`BFO_FLAG_C]
      ##1 status_flags[`BFO_FLAG_C] == $past(opnd[7]))
    else $error("rotate left through carry wrong");

  a_ror_carry: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    is_op(op_rotate_right_carry) |->
      rf.wr_data[7] == status_flags[`BFO_FLAG_C]
      ##1 status_flags[`BFO_FLAG_C] == $past(opnd[0]))
    else $error("rotate right through carry wrong");

  a_asr_sign: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    is_op(op_arith_shift_right) |->
      rf.wr_data[7] == opnd[7] && rf.wr_data[6:0] == opnd[7:1])
    else $error("arithmetic shift lost the sign");

  a_shift_flags: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    op_valid &&
      op_code inside {[op_shift_left_logical:op_arith_shift_right]} |=>
      status_flags[`BFO_FLAG_Z] == ($past(rf.wr_data) == 8'h00) &&
      status_flags[`BFO_FLAG_N] == $past(rf.wr_data[7]) &&
      status_flags[`BFO_FLAG_V] == ($past(rf.wr_data[7]) ^
        status_flags[`BFO_FLAG_C]) &&
      status_flags[`BFO_FLAG_S] == $past(status_flags[`BFO_FLAG_S]))
    else $error("shift flags wrong");

  a_swap_nibble: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    is_op(op_swap_nibbles) |->
      rf.wr_data == {opnd[3:0], opnd[7:4]} ##1 $stable(status_flags))
    else $error("swap wrong or flags touched");

  a_bit_raise: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    is_op(op_status_bit_raise) |=>
      status_flags == ($past(status_flags) | (8'h01 << $past(flag_sel))))
    else $error("generic flag set wrong");

  a_bit_drop: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    is_op(op_status_bit_drop) |=>
      status_flags == ($past(status_flags) & ~(8'h01 << $past(flag_sel))))
    else $error("generic flag clear wrong");

  a_store_t: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    is_op(op_store_bit_to_flag) |-> !rf.wr_en ##1
      status_flags[`BFO_FLAG_T] == $past(src[bit_sel]) &&
      status_flags[5:0] == $past(status_flags[5:0]) &&
      status_flags[`BFO_FLAG_I] == $past(status_flags[`BFO_FLAG_I]))
    else $error("store bit to flag wrong");

  a_load_bit: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    is_op(op_load_bit_from_flag) |->
      rf.wr_data[bit_sel] == status_flags[`BFO_FLAG_T] &&
      (rf.wr_data ^ opnd) == ((rf.wr_data ^ opnd) & (8'h01 << bit_sel))
      ##1 $stable(status_flags))
    else $error("load bit from flag wrong");

  a_carry_ops: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    is_op(op_carry_raise) || is_op(op_carry_drop) |=>
      status_flags[`BFO_FLAG_C] == $past(op_code == op_carry_raise) &&
      status_flags[7:1] == $past(status_flags[7:1]))
    else $error("carry operation wrong");

  a_neg_ops: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
    is_op(op_negative_raise) || is_op(op_negative_drop) |=>
      status_flags[`BFO_FLAG_N] == $past(op_code == op_negative_raise) &&
      (status_flags | 8'h04) == ($past(status_flags) | 8'h04))
    else $error("negative flag operation wrong");

  a_zero_ops: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
    is_op(op_zero_drop) |=> !status_flags[`BFO_FLAG_Z] &&
      (status_flags | 8'h02) == ($past(status_flags) | 8'h02))
    else $error("zero drop wrong");

  a_irq_ops: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
    is_op(op_irq_global_off) |=> !irq_enable [*1] ##0
      status_flags[6:0] == $past(status_flags[6:0]))
    else $error("global interrupt disable wrong");

  a_sign_ops: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
    is_op(op_sign_raise) |=> status_flags[`BFO_FLAG_S] &&
      (status_flags | 8'h10) == ($past(status_flags) | 8'h10))
    else $error("signed flag raise wrong");

  a_ovf_ops: assert property (@(posedge clk) disable iff (sys_rst) // RULE_16
    is_op(op_overflow_drop) |=> !status_flags[`BFO_FLAG_V] &&
      (status_flags | 8'h08) == ($past(status_flags) | 8'h08))
    else $error("overflow drop wrong");

  a_tflag_ops: assert property (@(posedge clk) disable iff (sys_rst) // RULE_17
    is_op(op_transfer_flag_raise) |=> status_flags[`BFO_FLAG_T] &&
      (status_flags | 8'h40) == ($past(status_flags) | 8'h40))
    else $error("transfer flag raise wrong");

  a_one_cycle: assert property (@(posedge clk) disable iff (sys_rst) // RULE_18
    is_op(op_swap_nibbles) ##1 bus_rd && bus_addr == {1'b0, $past(dst_sel)}
      && !op_valid |=> bus_rdata == $past(rf.wr_data, 2))
    else $error("result not ready after one cycle");

  a_same_dest: assert property (@(posedge clk) disable iff (sys_rst) // RULE_19
    op_valid && (op_code inside {[op_shift_left_logical:op_swap_nibbles],
      op_load_bit_from_flag}) |-> rf.wr_en && rf.wr_addr == dst_sel)
    else $error("result written to wrong register");

  c_shift: cover property (@(posedge clk) disable iff (sys_rst)
    is_op(op_rotate_left_carry) ##1 is_op(op_rotate_right_carry));

  c_bit_move: cover property (@(posedge clk) disable iff (sys_rst)
    is_op(op_store_bit_to_flag) ##1 is_op(op_load_bit_from_flag));

  c_flag_set: cover property (@(posedge clk) disable iff (sys_rst)
    is_op(op_status_bit_raise) ##1 is_op(op_irq_global_on));

  c_bus_read: cover property (@(posedge clk) disable iff (sys_rst)
    bus_rd && bus_addr == `BFO_ADDR_STATUS_FLAGS_REGISTER);
endmodule

// ===== test/bfo_decoder_model.sv
// Purpose: stand-in for the instruction decoder that feeds the unit
// Assumes: one operation per issue, driven by nba at a rising edge
// Notes: released select fields show the inverse of their last value
`include "bfo_defines.svh"
module bfo_decoder_model
  import bfo_pkg::*;
(
  input wire logic clk,
  output logic op_valid,
  output bfo_op_t op_code,
  output logic [`BFO_RAW-1:0] dst_sel,
  output logic [`BFO_RAW-1:0] src_sel,
  output logic [2:0] bit_sel,
  output logic [2:0] flag_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    op_valid = 1'b0;
    op_code = op_nop;
    dst_sel = '0;
    src_sel = '0;
    bit_sel = '0;
    flag_sel = '0;
  end

  // held until release_op, so two issues in a row go back to back
  task automatic issue(input bfo_op_t op, input int d, input int s,
                       input int b, input int f);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= op;
    dst_sel <= d[`BFO_RAW-1:0];
    src_sel <= s[`BFO_RAW-1:0];
    bit_sel <= b[2:0];
    flag_sel <= f[2:0];
  endtask

  // stale fields must not look like a valid request
  task automatic release_op;
    @(posedge clk);
    op_valid <= 1'b0;
    op_code <= op_nop;
    dst_sel <= ~dst_sel;
    src_sel <= ~src_sel;
    bit_sel <= ~bit_sel;
    flag_sel <= ~flag_sel;
  endtask
endmodule

// ===== test/test_bit_and_flag_ops_unit.sv
// Purpose: self-checking bench of the bit and flag operations unit
// Assumes: register port map 0x00-0x1F working regs, 0x20 status flags
// Notes: a shadow copy of regs and flags predicts every result
`include "bfo_defines.svh"
module test_bit_and_flag_ops_unit
  import bfo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [`BFO_BUS_AW-1:0] bus_addr = '0;
  logic [`BFO_DW-1:0] bus_wdata = '0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [`BFO_DW-1:0] bus_rdata;
  logic [`BFO_DW-1:0] status_flags;
  logic irq_enable;
  logic op_valid;
  bfo_op_t op_code;
  logic [`BFO_RAW-1:0] dst_sel;
  logic [`BFO_RAW-1:0] src_sel;
  logic [2:0] bit_sel;
  logic [2:0] flag_sel;
  int n_errors = 0;
  int total_checks = 0;
  logic [7:0] sh_regs [32];
  logic [7:0] sh_flags = 8'h00;
  localparam int named_bit [7] = '{`BFO_FLAG_C, `BFO_FLAG_N, `BFO_FLAG_Z,
    `BFO_FLAG_I, `BFO_FLAG_S, `BFO_FLAG_V, `BFO_FLAG_T};
  localparam logic [7:0] vals [4] = '{8'h81, 8'h00, 8'h40, 8'hFE};

  always #10 clk = ~clk;

  bfo_decoder_model dec (.clk(clk), .op_valid(op_valid), .op_code(op_code),
    .dst_sel(dst_sel), .src_sel(src_sel), .bit_sel(bit_sel),
    .flag_sel(flag_sel));

  bfo_unit dut (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
    .op_code(op_code), .dst_sel(dst_sel), .src_sel(src_sel),
    .bit_sel(bit_sel), .flag_sel(flag_sel), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .status_flags(status_flags),
    .irq_enable(irq_enable));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // expected effect of one operation on the shadow copy
  function automatic void predict(bfo_op_t op, int d, int s, int b, int f);
    logic [7:0] v;
    logic [7:0] r;
    logic c;
    logic sh;
    int idx;
    v = sh_regs[d];
    r = v;
    c = sh_flags[`BFO_FLAG_C];
    sh = 1'b1;
    idx = int'(op) - int'(op_carry_raise);
    case (op)
      op_shift_left_logical: r = {v[6:0], 1'b0};
      op_shift_right_logical: r = {1'b0, v[7:1]};
      op_rotate_left_carry: r = {v[6:0], c};
      op_rotate_right_carry: r = {c, v[7:1]};
      op_arith_shift_right: r = {v[7], v[7:1]};
      default: sh = 1'b0;
    endcase
    c = (op == op_shift_left_logical || op == op_rotate_left_carry) ?
        v[7] : v[0];
    if (sh) begin
      sh_flags[`BFO_FLAG_C] = c;
      sh_flags[`BFO_FLAG_Z] = (r == 8'h00);
      sh_flags[`BFO_FLAG_N] = r[7];
      sh_flags[`BFO_FLAG_V] = r[7] ^ c;
    end
    case (op)
      op_swap_nibbles: r = {v[3:0], v[7:4]};
      op_status_bit_raise: sh_flags[f] = 1'b1;
      op_status_bit_drop: sh_flags[f] = 1'b0;
      op_store_bit_to_flag: sh_flags[`BFO_FLAG_T] = sh_regs[s][b];
      op_load_bit_from_flag: r[b] = sh_flags[`BFO_FLAG_T];
      default: ;
    endcase
    if (idx >= 0 && idx < 14) begin
      sh_flags[named_bit[idx/2]] = ~idx[0];
    end
    sh_regs[d] = r;
  endfunction

  task automatic do_op(input bfo_op_t op, input int d, input int s,
                       input int b, input int f);
    dec.issue(op, d, s, b, f);
    dec.release_op;
    predict(op, d, s, b, f);
    @(negedge clk);
    check(status_flags, sh_flags);
    check({7'h00, irq_enable}, {7'h00, sh_flags[`BFO_FLAG_I]});
  endtask

  task automatic bus_write(input int a, input logic [7:0] d, input bit upd);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a[5:0];
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
    if (upd && a < 32) sh_regs[a] = d;
    if (upd && a == 32) sh_flags = d;
  endtask

  task automatic bus_read(input int a, input logic [7:0] exp);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a[5:0];
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    check(bus_rdata, exp);
    @(negedge clk);
    check(bus_rdata, 8'h00);
  endtask

  task automatic t_reset;
    check(status_flags, 8'h00);
    check({7'h00, irq_enable}, 8'h00);
    bus_read(32, 8'h00);
    bus_read(31, 8'h00);
  endtask

  task automatic t_shifts;
    int d;
    for (int o = 0; o < 5; o++) begin
      for (int k = 0; k < 4; k++) begin
        d = o * 7 + k;
        bus_write(32, k[0] ? 8'hFF : 8'h00, 1'b1);
        bus_write(d, vals[k], 1'b1);
        do_op(bfo_op_t'(int'(op_shift_left_logical) + o), d, 0, 0, 0);
        bus_read(d, sh_regs[d]);
      end
    end
  endtask

  task automatic t_swap_bits;
    bus_write(32, 8'h5A, 1'b1);
    bus_write(9, 8'hA6, 1'b1);
    do_op(op_swap_nibbles, 9, 0, 0, 0);
    bus_read(9, 8'h6A);
    for (int b = 0; b < 8; b++) begin
      do_op(op_store_bit_to_flag, 2, 9, b, 0);
      do_op(op_load_bit_from_flag, 12, 0, 7 - b, 0);
    end
    bus_read(12, 8'h56);
    bus_read(2, sh_regs[2]);
  endtask

  task automatic t_flags;
    bus_write(32, 8'h00, 1'b1);
    for (int s = 0; s < 8; s++) do_op(op_status_bit_raise, 0, 0, 0, s);
    for (int s = 0; s < 8; s++) do_op(op_status_bit_drop, 0, 0, 0, s);
    for (int i = 0; i < 14; i++) begin
      // flag_sel aimed elsewhere: named ops must ignore it
      do_op(bfo_op_t'(int'(op_carry_raise) + i), 0, 0, 0,
            ~named_bit[i/2]);
    end
    bus_write(32, 8'hFF, 1'b1);
    for (int i = 13; i >= 0; i--) begin
      do_op(bfo_op_t'(int'(op_carry_raise) + i), 0, 0, 0, 0);
    end
  endtask

  task automatic t_conflict;
    bus_write(7, 8'h3C, 1'b1);
    fork
      begin
        dec.issue(op_swap_nibbles, 7, 0, 0, 0);
        dec.release_op;
      end
      bus_write(7, 8'hFF, 1'b0);
    join
    predict(op_swap_nibbles, 7, 0, 0, 0);
    bus_read(7, 8'hC3);
    // read strobe in the very cycle after the operation
    predict(op_swap_nibbles, 7, 0, 0, 0);
    fork
      begin
        dec.issue(op_swap_nibbles, 7, 0, 0, 0);
        dec.release_op;
      end
      begin
        @(posedge clk);
        bus_read(7, 8'h3C);
      end
    join
    dec.issue(op_shift_left_logical, 7, 0, 0, 0);
    predict(op_shift_left_logical, 7, 0, 0, 0);
    dec.issue(op_rotate_left_carry, 7, 0, 0, 0);
    predict(op_rotate_left_carry, 7, 0, 0, 0);
    dec.release_op;
    @(negedge clk);
    check(status_flags, sh_flags);
    bus_read(7, sh_regs[7]);
    do_op(op_nop, 7, 0, 0, 0);
    bus_write(42, 8'hFF, 1'b0);
    bus_read(42, 8'h00);
    bus_read(32, sh_flags);
  endtask

  initial begin
    for (int i = 0; i < 32; i++) sh_regs[i] = 8'h00;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_shifts();
    t_swap_bits();
    t_flags();
    t_conflict();
    test_done();
  end

  // runs take a few hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule
